// ==== pkg/timer0_pkg.sv ====
// Package with register map, field layout and prescaler constants for timer 0.
//
// Overview of operation
// (R1) Clock select picks stop, core, divided, pin edges.
// (R2) Prescaler reset bit self-clears, reads zero.
// (R3) Control bits seven to four read zero.
// (R4) Count pin synchronised to core clock first.
// (R5) Pin transitions spaced at least one period.
// (R6) Counter is eight-bit up, read and write.
// (R7) Written count resumes on next timer tick.
// (R8) Overflow flag in flag register, masked interrupt.
// (R9) Software makes count pin an input first.
// (R10) One prescaler feeds divided clocks; stop disables.
// (R11) Overflow flag set on wrap FF to 00.
package timer0_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses.
    localparam logic [11:0] ADDR_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_COUNT   = 12'h004;
    localparam logic [11:0] ADDR_FLAG    = 12'h008;
    localparam logic [11:0] ADDR_MASK    = 12'h00C;

    // Field positions.
    localparam int PRESCALER_RESET_POS = 3;
    localparam int OVERFLOW_POS        = 0;

    // Reset values.
    localparam logic [7:0] COUNT_RESET  = 8'h00;
    localparam logic [2:0] SELECT_RESET = 3'h0;

    // Prescaler width and tap points for the divided selections.
    localparam int PRESCALER_WIDTH = 10;
    localparam logic [9:0] DIV8_MASK    = 10'h007;
    localparam logic [9:0] DIV64_MASK   = 10'h03F;
    localparam logic [9:0] DIV256_MASK  = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;

    // Clock select encodings.
    typedef enum logic [2:0] {
        SEL_STOP    = 3'h0,
        SEL_CORE    = 3'h1,
        SEL_DIV8    = 3'h2,
        SEL_DIV64   = 3'h3,
        SEL_DIV256  = 3'h4,
        SEL_DIV1024 = 3'h5,
        SEL_FALL    = 3'h6,
        SEL_RISE    = 3'h7
    } clock_select_t;

endpackage

// ==== pkg/tick_if.sv ====
// Interface carrying prescaler control and timer tick between modules.
interface tick_if;
    import timer0_pkg::*;
    logic          clear;
    clock_select_t select;
    logic          pin_sync;
    logic          tick;

    modport source (input clear, input select, input pin_sync, output tick);
    modport sink   (output clear, output select, output pin_sync, input tick);
endinterface

// ==== rtl/timer0_tick_source.sv ====
// Prescaler and clock source selection producing a one-cycle timer tick.
module timer0_tick_source
    import timer0_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    tick_if.source    tk
);
    logic [PRESCALER_WIDTH-1:0] prescale_reg;
    logic                       pin_last_reg;

    ////////////////////////////////////////////////////////////////////////////
    // One free prescaler from the core clock, cleared on request.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_reg <= '0;
        end else if (tk.clear) begin
            prescale_reg <= '0; // R2
        end else begin
            prescale_reg <= prescale_reg + 10'h001; // R10
        end
    end

    // Previous synchronised pin level for edge detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_last_reg <= 1'b0;
        end else begin
            pin_last_reg <= tk.pin_sync; // R4
        end
    end

    // Tick selection; a divided tick fires when its low bits are all ones.
    always_comb begin
        case (tk.select) // R1
            SEL_STOP:    tk.tick = 1'b0; // R10
            SEL_CORE:    tk.tick = 1'b1;
            SEL_DIV8:    tk.tick = &(prescale_reg | ~DIV8_MASK);
            SEL_DIV64:   tk.tick = &(prescale_reg | ~DIV64_MASK);
            SEL_DIV256:  tk.tick = &(prescale_reg | ~DIV256_MASK);
            SEL_DIV1024: tk.tick = &(prescale_reg | ~DIV1024_MASK);
            SEL_FALL:    tk.tick = pin_last_reg & ~tk.pin_sync; // R4
            SEL_RISE:    tk.tick = ~pin_last_reg & tk.pin_sync; // R4
            default:     tk.tick = 1'b0;
        endcase
    end
endmodule

// ==== rtl/timer0_counter.sv ====
// Timer 0 counter with APB registers, prescaler and overflow interrupt.
module timer0_counter
    import timer0_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_pin,
    output logic             irq
);
    import timer0_pkg::*;

    tick_if tk ();

    clock_select_t select_reg;
    logic          clear_reg;
    logic [7:0]    count_reg;
    logic [7:0]    count_next;
    logic          flag_reg;
    logic          mask_reg;
    logic          pin_meta_reg;
    logic          pin_sync_reg;
    logic          wr_en;
    logic          rd_en;
    logic          mapped;
    logic          overflow;
    logic [31:0]   read_next;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode: zero-wait slave, access phase completes in one cycle.
    assign wr_en  = psel & penable & pwrite;
    assign rd_en  = psel & penable & ~pwrite;
    assign mapped = (paddr == ADDR_CONTROL) || (paddr == ADDR_COUNT) ||
                    (paddr == ADDR_FLAG) || (paddr == ADDR_MASK);

    // Ready and error are registered: high in the setup-following cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser for the count pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= external_count_pin; // R4
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign tk.clear    = clear_reg;
    assign tk.select   = select_reg;
    assign tk.pin_sync = pin_sync_reg;

    // Prescaler and tick generation.
    timer0_tick_source u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tk      (tk.source)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control register: clock select stored, prescaler reset pulses once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_reg <= clock_select_t'(SELECT_RESET);
            clear_reg  <= 1'b0;
        end else begin
            clear_reg <= 1'b0; // R2
            if (wr_en && pready && paddr == ADDR_CONTROL) begin
                select_reg <= clock_select_t'(pwdata[2:0]); // R1
                clear_reg  <= pwdata[PRESCALER_RESET_POS]; // R2
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter: a write loads the value, later ticks count up from it.
    always_comb begin
        count_next = count_reg;
        overflow   = 1'b0;
        if (wr_en && pready && paddr == ADDR_COUNT) begin
            count_next = pwdata[7:0]; // R7
        end else if (tk.tick) begin
            count_next = count_reg + 8'h01; // R6
            overflow   = (count_reg == 8'hFF); // R11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= COUNT_RESET;
        end else begin
            count_reg <= count_next; // R6
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flag: write one clears, a new overflow wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
        end else if (overflow) begin
            flag_reg <= 1'b1; // R8 R11
        end else if (wr_en && pready && paddr == ADDR_FLAG && pwdata[OVERFLOW_POS]) begin
            flag_reg <= 1'b0;
        end
    end

    // Interrupt mask register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= 1'b0;
        end else if (wr_en && pready && paddr == ADDR_MASK) begin
            mask_reg <= pwdata[OVERFLOW_POS];
        end
    end

    // Level interrupt, registered from the current flag and mask, so it lags by one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= flag_reg & mask_reg; // R8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data mux; reserved and self-clearing bits read zero.
    always_comb begin
        read_next = 32'h00000000;
        case (paddr)
            ADDR_CONTROL: read_next = {29'h0, select_reg}; // R3 R2
            ADDR_COUNT:   read_next = {24'h0, count_reg}; // R6
            ADDR_FLAG:    read_next = {31'h0, flag_reg};
            ADDR_MASK:    read_next = {31'h0, mask_reg};
            default:      read_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= read_next;
        end
    end
endmodule

// ==== bench/timer0_counter_sva.sv ====
// Checker for the timer 0 APB port and interrupt output.
module timer0_counter_sva
    import timer0_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        external_count_pin,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc, rd, mapped, mask_sh;
    // Completed access, read, and a decode of the four mapped words.
    assign acc    = psel && penable && pready;
    assign rd     = acc && !pwrite;
    assign mapped = paddr inside {ADDR_CONTROL, ADDR_COUNT, ADDR_FLAG, ADDR_MASK};
    // Shadow of the mask bit as software last wrote it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mask_sh <= 1'b0;
        else if (acc && pwrite && paddr == ADDR_MASK) mask_sh <= pwdata[0];
    end
    ////////////////////////////////////////
    pready_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    bus_err_a: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    unmapped_rd_a: assert property (rd && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    ctrl_reserved_a: assert property (rd && paddr == ADDR_CONTROL |-> prdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    psr_zero_a: assert property (rd && paddr == ADDR_CONTROL |-> !prdata[3])
        else $error("prescaler reset bit reads one");
    count_width_a: assert property (rd && paddr == ADDR_COUNT |-> prdata[31:8] == 24'h0)
        else $error("count wider than eight bits");
    irq_masked_a: assert property (irq |-> $past(mask_sh))
        else $error("irq high while masked");
    cover property (rd && paddr == ADDR_COUNT);
    cover property ($rose(irq));
    cover property (acc && pslverr);
endmodule

// ==== bench/pin_source.sv ====
// Model of the external pulse source on the count pin.
module pin_source (
    input wire logic pclk,
    output logic     pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin idles low; each pulse is high one cycle then low one cycle.
    // Only this model drives the count pin; the block treats it as an input.
    initial pin = 1'b0;
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge pclk) pin <= 1'b1;
            @(posedge pclk) pin <= 1'b0;
        end
    endtask
endmodule

// ==== bench/timer0_counter_tb.sv ====
// Self-checking testbench for the timer 0 counter block.
module timer0_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import timer0_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, pin, irq;
    int          err_total = 0, num_checks = 0;
    // Clock of 50 ns period.
    always #25 pclk = ~pclk;
    timer0_counter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_pin(pin), .irq(irq));
    pin_source u_src (.pclk(pclk), .pin(pin));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pready}, 32'h1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        rdc(ADDR_CONTROL, 32'h0);
        rdc(ADDR_COUNT, 32'h0);
        rdc(ADDR_FLAG, 32'h0);
        rdc(ADDR_MASK, 32'h0);
        rdc(12'h010, 32'h0);
        wr(ADDR_CONTROL, 32'hFA);
        rdc(ADDR_CONTROL, 32'h2);
        $display("t_reset done");
    endtask
    task automatic t_div;
        int dv[5] = '{1, 8, 64, 256, 1024};
        logic [31:0] r;
        for (int s = 1; s <= 5; s++) begin
            wr(ADDR_CONTROL, 32'h0);
            wr(ADDR_COUNT, 32'h0);
            wr(ADDR_CONTROL, 32'h8 | s);
            repeat (4 * dv[s-1]) @(posedge pclk);
            wr(ADDR_CONTROL, 32'h0);
            apb(1'b0, ADDR_COUNT, 32'h0, r);
            chk(r >= (s == 1 ? 4 : 3) && r <= (s == 1 ? 7 : 5), 32'h1);
            repeat (20) @(posedge pclk);
            rdc(ADDR_COUNT, r);
        end
        $display("t_div done");
    endtask
    task automatic t_ext;
        for (int s = 6; s <= 7; s++) begin
            wr(ADDR_COUNT, 32'h0);
            wr(ADDR_CONTROL, s);
            u_src.pulses(3);
            repeat (6) @(posedge pclk);
            rdc(ADDR_COUNT, 32'h3);
        end
        $display("t_ext done");
    endtask
    task automatic t_ovf;
        int n = 0;
        wr(ADDR_MASK, 32'h1);
        wr(ADDR_CONTROL, 32'h1);
        wr(ADDR_COUNT, 32'hFE);
        while (irq !== 1'b1 && n++ < 10) @(posedge pclk);
        wr(ADDR_CONTROL, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rdc(ADDR_FLAG, 32'h1);
        wr(ADDR_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_FLAG, 32'h1);
        rdc(ADDR_FLAG, 32'h0);
        $display("t_ovf done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence after ten cycles of reset.
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_div;
        t_ext;
        t_ovf;
        tally_and_finish;
    end
    // Watchdog well beyond the expected run of about 5700 cycles.
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        tally_and_finish;
    end
endmodule
bind timer0_counter timer0_counter_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_pin(external_count_pin), .irq(irq));
